// ---- hw/asp_pkg.sv ----
package asp_pkg;

	// ****************************************************************
	// pins and clock
	// ****************************************************************
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic din;
	} asp_pins_t;

	localparam int CLK_PERIOD_NS = 4;
	localparam logic [2:0] PIN_RESET = 3'h6;

	// ****************************************************************
	// frame layout
	// ****************************************************************
	localparam int CTRL_BITS   = 8;
	localparam int RESULT_BITS = 12;
	localparam int LEAD_ZEROS  = 4;

	localparam logic [4:0] FRAME_EDGES = 5'h10;
	localparam logic [4:0] SAMPLE_EDGE = 5'h02;
	localparam logic [4:0] CTRL_EDGE   = 5'h08;
	localparam logic [4:0] LAST_ZERO   = 5'h04;

	// ****************************************************************
	// control byte fields
	// ****************************************************************
	localparam int PM_HI_POS = 1;
	localparam int PM_LO_POS = 0;
	localparam int CHAN_POS  = 3;

	localparam logic [7:0] CTRL_RESET = 8'h00;

	typedef enum logic [1:0] {
		PM_CS_GATED  = 2'b00,
		PM_ALWAYS_ON = 2'b01,
		PM_AUTO_OFF  = 2'b10,
		PM_AUTO_STBY = 2'b11
	} asp_pm_t;

	typedef enum logic [1:0] {
		PWR_OFF  = 2'b00,
		PWR_STBY = 2'b01,
		PWR_ON   = 2'b10
	} asp_pwr_t;

	// ****************************************************************
	// power-up delays, longest times round down
	// ****************************************************************
	localparam int TMR_W = 11;
	localparam int PWRUP_FULL_NS = 5000;
	localparam int PWRUP_STBY_NS = 1000;
	localparam logic [TMR_W-1:0] PWRUP_FULL_CYC =
		TMR_W'(PWRUP_FULL_NS / CLK_PERIOD_NS);
	localparam logic [TMR_W-1:0] PWRUP_STBY_CYC =
		TMR_W'(PWRUP_STBY_NS / CLK_PERIOD_NS);

endpackage

// ---- hw/asp_sync.sv ----
`timescale 1ns/100ps

module asp_sync #(
	parameter int             W       = 3,
	parameter logic [W-1:0]   RST_VAL = '0
) (
	input  wire logic         sys_clk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] level_out
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
	} asp_sync_t;

	asp_sync_t q;
	asp_sync_t d;

	// a bit only moves once the second and third stage agree
	always_comb begin
		d = q;
		d.s1 = d_in;
		d.s2 = q.s1;
		d.s3 = q.s2;
		for (int i = 0; i < W; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				d.lvl[i] = q.s2[i];
			end
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			q <= '{RST_VAL, RST_VAL, RST_VAL, RST_VAL};
		end else begin
			q <= d;
		end
	end

	assign level_out = q.lvl;

endmodule

// ---- hw/asp_timer.sv ----
`timescale 1ns/100ps

module asp_timer #(
	parameter int W = 11
) (
	input  wire logic         sys_clk_in,
	input  wire logic         rst_in,
	input  wire logic         start_in,
	input  wire logic         clear_in,
	input  wire logic [W-1:0] load_in,
	output logic              done_out
);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic         done;
	} asp_timer_t;

	asp_timer_t q;
	asp_timer_t d;

	// clear wins so a power-down never leaves a stale ready
	always_comb begin
		d = q;
		if (clear_in) begin
			d.cnt = '0;
			d.done = 1'b0;
		end else if (start_in) begin
			d.cnt = load_in;
			d.done = 1'b0;
		end else if (q.cnt > W'(1)) begin
			d.cnt = q.cnt - W'(1);
		end else if (q.cnt == W'(1)) begin
			d.cnt = '0;
			d.done = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			q <= '{'0, 1'b0};
		end else begin
			q <= d;
		end
	end

	assign done_out = q.done;

endmodule

// ---- hw/asp_core.sv ----
`timescale 1ns/100ps

// Behaviour
// - mode 1,0 powers fully down at the end of every conversion.
// - in auto-shutdown the chip-select level never changes power state.
// - auto-shutdown powers up on first falling clock, up to 5 us.
// - second rising clock samples input, enters hold, starts conversion.
// - acquisition spans first 1.5 clocks; host stretches it for power-up.
// - conversion completes 14 clocks after the sampling edge.
// - mode 1,1 enters standby after conversion; only reference stays on.
// - auto-standby leaves standby on first falling clock, about 1 us.
// - auto-standby returns to standby after last rising clock.
// - select low gates clock in, tracks, and powers up in mode 0,0.
// - select rising after conversion puts data output in high impedance.
// - select held low lets a new conversion start without reselecting.
// - result belongs to channel written in the previous control write.
// - control byte loads from first eight rising clocks of every frame.
// - each frame uses sixteen serial clock cycles.
// - leading falling edge enables output with the first leading zero.
// - later bits launch on falling edge, valid at next rising edge.
// - last bit launches before and is valid at sixteenth rising edge.
// - after reset mode is 0,0.
// - mode 0,0 powers down on select high, up on select low.
// - mode 0,1 stays powered; host rewrites it every frame.
module asp_core (
	input  wire logic                   sys_clk_in,
	input  wire logic                   rst_in,
	input  wire asp_pkg::asp_pins_t     pins_in,
	input  wire logic [11:0]            sample_data_in,
	output logic                        dout_out,
	output logic                        dout_oe_out,
	output logic                        track_out,
	output logic                        conv_start_out,
	output logic                        conv_busy_out,
	output logic                        frame_done_out,
	output logic                        channel_out,
	output logic [7:0]                  ctrl_out,
	output logic                        powered_out,
	output logic                        ref_on_out,
	output logic                        ready_out
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic             cs_n;
		logic             sclk;
		logic             in_frame;
		logic [4:0]       rise_cnt;
		logic [4:0]       fall_cnt;
		logic             fall_seen;
		logic             rise_first;
		logic [7:0]       shift;
		logic [7:0]       ctrl;
		logic             chan;
		logic [11:0]      result;
		logic             dout;
		logic             dout_oe;
		logic             track;
		logic             conv_start;
		logic             conv_busy;
		logic             frame_done;
		asp_pkg::asp_pwr_t pwr;
		logic             powered;
		logic             ref_on;
	} asp_core_t;

	localparam asp_core_t ST_RESET = '{
		cs_n:       1'b1,
		sclk:       1'b1,
		in_frame:   1'b0,
		rise_cnt:   5'h00,
		fall_cnt:   5'h00,
		fall_seen:  1'b0,
		rise_first: 1'b0,
		shift:      8'h00,
		ctrl:       asp_pkg::CTRL_RESET,
		chan:       1'b0,
		result:     12'h000,
		dout:       1'b0,
		dout_oe:    1'b0,
		track:      1'b0,
		conv_start: 1'b0,
		conv_busy:  1'b0,
		frame_done: 1'b0,
		pwr:        asp_pkg::PWR_OFF,
		powered:    1'b0,
		ref_on:     1'b0
	};

	asp_core_t                  q;
	asp_core_t                  d;
	asp_pkg::asp_pins_t         pins_s;
	logic                       tmr_start;
	logic                       tmr_clear;
	logic [asp_pkg::TMR_W-1:0]  tmr_load;
	logic                       tmr_done;

	// ****************************************************************
	// pin synchroniser and power-up timer
	// ****************************************************************
	asp_sync #(
		.W       (3),
		.RST_VAL (asp_pkg::PIN_RESET)
	) asp_sync_inst (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.d_in       (pins_in),
		.level_out  (pins_s)
	);

	asp_timer #(
		.W (asp_pkg::TMR_W)
	) asp_timer_inst (
		.sys_clk_in (sys_clk_in),
		.rst_in     (rst_in),
		.start_in   (tmr_start),
		.clear_in   (tmr_clear),
		.load_in    (tmr_load),
		.done_out   (tmr_done)
	);

	// ****************************************************************
	// frame and power sequencing
	// ****************************************************************
	always_comb begin
		logic              cs_fall;
		logic              cs_rise;
		logic              sclk_rise;
		logic              sclk_fall;
		logic [4:0]        k;
		logic [4:0]        idx;
		logic [7:0]        ctrl_new;
		asp_pkg::asp_pm_t  mode;
		cs_fall = 1'b0;
		cs_rise = 1'b0;
		sclk_rise = 1'b0;
		sclk_fall = 1'b0;
		k = 5'h00;
		idx = 5'h00;
		ctrl_new = 8'h00;
		mode = asp_pkg::asp_pm_t'({q.ctrl[asp_pkg::PM_HI_POS],
			q.ctrl[asp_pkg::PM_LO_POS]});
		d = q;
		d.cs_n = pins_s.cs_n;
		d.sclk = pins_s.sclk;
		d.conv_start = 1'b0;
		d.frame_done = 1'b0;
		tmr_start = 1'b0;
		tmr_clear = 1'b0;
		tmr_load = asp_pkg::PWRUP_FULL_CYC;

		// ********************************************************
		// pin edges
		// ********************************************************
		cs_fall = q.cs_n & ~pins_s.cs_n;
		cs_rise = ~q.cs_n & pins_s.cs_n;
		// clock edges only count inside a frame
		sclk_rise = q.in_frame & ~pins_s.cs_n & ~q.sclk & pins_s.sclk;
		sclk_fall = q.in_frame & ~pins_s.cs_n & q.sclk & ~pins_s.sclk;

		if (cs_rise) begin
			// aborts any frame; output floats at once
			d.in_frame = 1'b0;
			d.dout_oe = 1'b0;
			d.dout = 1'b0;
			d.track = 1'b0;
			d.conv_busy = 1'b0;
			if (mode == asp_pkg::PM_CS_GATED) begin
				d.pwr = asp_pkg::PWR_OFF;
			end
		end else if (cs_fall) begin
			d.in_frame = 1'b1;
			d.rise_cnt = 5'h00;
			d.fall_cnt = 5'h00;
			d.fall_seen = 1'b0;
			d.rise_first = 1'b0;
			d.track = 1'b1;
			if (mode == asp_pkg::PM_CS_GATED && q.pwr != asp_pkg::PWR_ON) begin
				d.pwr = asp_pkg::PWR_ON;
				tmr_start = 1'b1;
			end
		end else if (sclk_fall) begin
			k = q.fall_cnt + 5'h01;
			if (q.fall_cnt != asp_pkg::FRAME_EDGES) begin
				d.fall_cnt = k;
			end
			// auto modes wake on the frame's first falling edge
			if (!q.fall_seen && q.pwr != asp_pkg::PWR_ON) begin
				if (mode == asp_pkg::PM_AUTO_OFF) begin
					d.pwr = asp_pkg::PWR_ON;
					tmr_start = 1'b1;
					tmr_load = asp_pkg::PWRUP_FULL_CYC;
				end else if (mode == asp_pkg::PM_AUTO_STBY) begin
					d.pwr = asp_pkg::PWR_ON;
					tmr_start = 1'b1;
					tmr_load = asp_pkg::PWRUP_STBY_CYC;
				end
			end
			d.dout_oe = 1'b1;
			d.fall_seen = 1'b1;
			if (k <= asp_pkg::LAST_ZERO || k > asp_pkg::FRAME_EDGES) begin
				d.dout = 1'b0;
			end else begin
				// result msb first after the leading zeros
				idx = asp_pkg::FRAME_EDGES - k;
				d.dout = q.result[idx[3:0]];
			end
		end else if (sclk_rise) begin
			k = q.rise_cnt + 5'h01;
			d.rise_cnt = k;
			if (k == 5'h01 && (!q.fall_seen || q.rise_first)) begin
				// select fall stood in for the first falling edge
				d.rise_first = 1'b1;
				d.fall_seen = 1'b0;
				d.fall_cnt = 5'h01;
			end
			if (k <= asp_pkg::CTRL_EDGE) begin
				d.shift = {q.shift[6:0], pins_s.din};
			end
			if (k == asp_pkg::CTRL_EDGE) begin
				ctrl_new = {q.shift[6:0], pins_s.din};
				d.ctrl = ctrl_new;
				if (ctrl_new[asp_pkg::PM_HI_POS] == 1'b0 &&
					ctrl_new[asp_pkg::PM_LO_POS] == 1'b1 &&
					q.pwr != asp_pkg::PWR_ON) begin
					d.pwr = asp_pkg::PWR_ON;
					tmr_start = 1'b1;
				end
			end
			if (k == asp_pkg::SAMPLE_EDGE) begin
				// channel from the previous write, new byte lands later
				d.track = 1'b0;
				d.conv_start = 1'b1;
				d.conv_busy = 1'b1;
				d.result = sample_data_in;
				d.chan = q.ctrl[asp_pkg::CHAN_POS];
			end
			if (k == asp_pkg::FRAME_EDGES) begin
				// restart counting so a held select begins a new frame
				d.frame_done = 1'b1;
				d.conv_busy = 1'b0;
				d.rise_cnt = 5'h00;
				if (q.rise_first) begin
					// trailing falling edge still belongs to this frame
					d.fall_cnt = asp_pkg::FRAME_EDGES;
				end else begin
					d.fall_cnt = 5'h00;
					d.fall_seen = 1'b0;
				end
				d.track = 1'b1;
				if (mode == asp_pkg::PM_AUTO_OFF) begin
					d.pwr = asp_pkg::PWR_OFF;
				end else if (mode == asp_pkg::PM_AUTO_STBY) begin
					d.pwr = asp_pkg::PWR_STBY;
				end
			end
		end

		// ********************************************************
		// power flags
		// ********************************************************
		d.powered = (d.pwr == asp_pkg::PWR_ON);
		d.ref_on  = (d.pwr != asp_pkg::PWR_OFF);
		if (d.pwr != asp_pkg::PWR_ON) begin
			tmr_clear = 1'b1;
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			q <= ST_RESET;
		end else begin
			q <= d;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign dout_out       = q.dout;
	assign dout_oe_out    = q.dout_oe;
	assign track_out      = q.track;
	assign conv_start_out = q.conv_start;
	assign conv_busy_out  = q.conv_busy;
	assign frame_done_out = q.frame_done;
	assign channel_out    = q.chan;
	assign ctrl_out       = q.ctrl;
	assign powered_out    = q.powered;
	assign ref_on_out     = q.ref_on;
	assign ready_out      = tmr_done;

endmodule

// ---- tb/asp_core_monitor.sv ----
`timescale 1ns/100ps

module asp_core_monitor (
	input  wire logic               sys_clk_in,
	input  wire logic               rst_in,
	input  wire asp_pkg::asp_pins_t pins_in,
	input  wire logic               dout_oe_out,
	input  wire logic               track_out,
	input  wire logic               conv_start_out,
	input  wire logic               conv_busy_out,
	input  wire logic               frame_done_out,
	input  wire logic               channel_out,
	input  wire logic [7:0]         ctrl_out,
	input  wire logic               powered_out,
	input  wire logic               ref_on_out,
	input  wire logic               ready_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	localparam logic [11:0] WAKE_MAX =
		12'(asp_pkg::PWRUP_FULL_CYC) + 12'h002;

	// cycles spent powered but not yet ready, saturating
	logic [11:0] wake_cnt;

	always_ff @(posedge sys_clk_in) begin
		if (rst_in || !powered_out || ready_out) begin
			wake_cnt <= 12'h000;
		end else if (wake_cnt != 12'hFFF) begin
			wake_cnt <= wake_cnt + 12'h001;
		end
	end

	sequence s_hold_begin;
		conv_busy_out && !track_out ##1 !conv_start_out;
	endsequence

	property p_reset;
		$fell(rst_in) |-> ctrl_out == 8'h00 && !powered_out && !dout_oe_out;
	endproperty
	property p_start;
		conv_start_out |-> s_hold_begin;
	endproperty
	property p_chan;
		conv_start_out |-> channel_out == ctrl_out[3];
	endproperty
	property p_done;
		frame_done_out |-> !conv_busy_out && $past(conv_busy_out) && track_out;
	endproperty
	property p_auto_off;
		frame_done_out && ctrl_out[1:0] == 2'h2
			|-> ##[0:1] (!powered_out && !ref_on_out);
	endproperty
	property p_stby;
		frame_done_out && ctrl_out[1:0] == 2'h3
			|-> ##[0:1] (!powered_out && ref_on_out);
	endproperty
	property p_cs_off;
		$rose(pins_in.cs_n) && ctrl_out[1:0] == 2'h0 |-> ##[1:6] !powered_out;
	endproperty
	property p_on;
		ctrl_out[1:0] == 2'h1 && powered_out |=> powered_out;
	endproperty
	property p_hiz;
		pins_in.cs_n [*8] |-> !dout_oe_out;
	endproperty
	// power-up delay may not be skipped
	property p_ready;
		$rose(powered_out) |=> (!ready_out) [*8];
	endproperty
	property p_wake;
		wake_cnt <= WAKE_MAX;
	endproperty

	a_reset: assert property (p_reset)
		else $error("state after reset wrong");
	a_start: assert property (p_start)
		else $error("sampling edge without hold");
	a_chan: assert property (p_chan)
		else $error("channel not from previous write");
	a_done: assert property (p_done)
		else $error("frame end wrong");
	a_auto_off: assert property (p_auto_off)
		else $error("no shutdown after conversion");
	a_stby: assert property (p_stby)
		else $error("no standby after conversion");
	a_cs_off: assert property (p_cs_off)
		else $error("select high did not power down");
	a_on: assert property (p_on)
		else $error("always-on mode lost power");
	a_hiz: assert property (p_hiz)
		else $error("output driven while deselected");
	a_ready: assert property (p_ready)
		else $error("ready too soon after power-up");
	a_wake: assert property (p_wake)
		else $error("power-up delay too long");
endmodule

bind asp_core asp_core_monitor asp_core_monitor_inst (
	.sys_clk_in(sys_clk_in), .rst_in(rst_in), .pins_in(pins_in),
	.dout_oe_out(dout_oe_out), .track_out(track_out),
	.conv_start_out(conv_start_out), .conv_busy_out(conv_busy_out),
	.frame_done_out(frame_done_out), .channel_out(channel_out),
	.ctrl_out(ctrl_out), .powered_out(powered_out),
	.ref_on_out(ref_on_out), .ready_out(ready_out)
);

// ---- tb/asp_host.sv ----
`timescale 1ns/100ps

module asp_host (
	input  wire logic sys_clk_in,
	input  wire logic dout_in,
	input  wire logic dout_oe_in,
	output logic      cs_n_out,
	output logic      sclk_out,
	output logic      din_out
);
	logic [15:0] rx_word = 16'h0000;
	event        rx_got;

	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b1;
		din_out  = 1'b0;
	end

	task automatic hold(input int n);
		repeat (n) @(negedge sys_clk_in);
	endtask

	task automatic idle_clocks(input int n);
		repeat (2 * n) begin
			sclk_out = ~sclk_out;
			hold(10);
		end
	endtask

	task automatic frame(input logic [7:0] ctrl, input int gap,
			input logic keep, input logic rise1);
		// idle level moves only while deselected
		if (sclk_out == rise1) begin
			sclk_out = ~rise1;
			hold(10);
		end
		cs_n_out = 1'b0;
		hold(10);
		for (int i = 0; i < 16; i++) begin
			sclk_out = 1'b0;
			din_out  = (i < 8) ? ctrl[7 - i] : ~din_out;
			// stretch before the sampling edge to cover power-up
			hold((i == int'(rise1)) ? 10 + gap : 10);
			// a released line reads as junk, never as a clean bit
			rx_word = {rx_word[14:0], dout_oe_in ? dout_in : ~rx_word[0]};
			sclk_out = 1'b1;
			hold(10);
		end
		if (rise1) begin
			sclk_out = 1'b0;
			hold(10);
		end
		if (!keep) begin
			cs_n_out = 1'b1;
			din_out  = ~din_out;
		end
		hold(10);
		-> rx_got;
	endtask
endmodule

// ---- tb/asp_core_tb.sv ----
`timescale 1ns/100ps

module asp_core_tb;
	typedef struct packed {
		logic [15:0] rx;
		logic [7:0]  ctrl;
		logic        chan;
		logic        pw;
		logic        ref_on;
		logic        keep;
		logic        rise1;
	} asp_exp_t;

	logic        sys_clk_in = 1'b0;
	logic        rst_in     = 1'b1;
	logic [11:0] sample_val = 12'h000;
	logic        cs_n, sclk, din, dout, dout_oe, chan, pw, ref_on, rdy;
	logic [7:0]  ctrl;
	asp_exp_t    exp_q[$];
	int          n_errors   = 0;
	int          compares   = 0;
	logic [1:0]  modes [10] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h0, 2'h0, 2'h1,
		2'h3, 2'h3, 2'h2};

	always #2 sys_clk_in = ~sys_clk_in;

	asp_core asp_core_inst (
		.sys_clk_in(sys_clk_in), .rst_in(rst_in), .pins_in({cs_n, sclk, din}),
		.sample_data_in(sample_val), .dout_out(dout), .dout_oe_out(dout_oe),
		.track_out(), .conv_start_out(), .conv_busy_out(), .frame_done_out(),
		.channel_out(chan), .ctrl_out(ctrl), .powered_out(pw),
		.ref_on_out(ref_on), .ready_out(rdy)
	);
	asp_host asp_host_inst (
		.sys_clk_in(sys_clk_in), .dout_in(dout), .dout_oe_in(dout_oe),
		.cs_n_out(cs_n), .sclk_out(sclk), .din_out(din)
	);

	// ****************************************************************
	// checking
	// ****************************************************************
	task automatic check(input logic [15:0] got, input logic [15:0] want,
			input string what);
		compares++;
		if (got !== want) begin
			n_errors++;
			$display("mismatch at %0t: %s", $time, what);
		end
	endtask

	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	initial begin
		asp_exp_t    e;
		logic [15:0] rx;
		forever begin
			@(asp_host_inst.rx_got);
			e = exp_q.pop_front();
			rx = asp_host_inst.rx_word;
			// a rising-first frame need not set up its first zero in time
			if (e.rise1)
				rx[15] = 1'b0;
			check(rx, e.rx, "result word");
			check(16'(ctrl), 16'(e.ctrl), "control byte");
			check(16'(chan), 16'(e.chan), "channel");
			check(16'(pw), 16'(e.pw), "power state");
			check(16'(ref_on), 16'(e.ref_on), "reference");
			check(16'(rdy), 16'(e.pw), "ready");
			if (!e.keep)
				check(16'(dout_oe), 16'h0000, "output enable");
		end
	end

	// ****************************************************************
	// stimulus
	// ****************************************************************
	initial begin
		logic [7:0] c;
		logic [7:0] prev;
		asp_exp_t   e;
		void'($urandom(80));
		prev = 8'h00;
		repeat (4) @(negedge sys_clk_in);
		rst_in = 1'b0;
		asp_host_inst.idle_clocks(3);
		foreach (modes[k]) begin
			c = 8'($urandom);
			c[1:0] = modes[k];
			sample_val = 12'($urandom);
			e.keep = (k == 4);
			e.rise1 = (k == 3 || k >= 7);
			e.rx = {4'h0, sample_val};
			e.ctrl = c;
			e.chan = prev[3];
			e.pw = c[1:0] == 2'h1 || (c[1:0] == 2'h0 && e.keep);
			e.ref_on = e.pw || c[1:0] == 2'h3;
			exp_q.push_back(e);
			// standby wakes fast, full power-up needs the long gap
			asp_host_inst.frame(c, (prev[1:0] == 2'h3) ? 260 : 1260,
				e.keep, e.rise1);
			$display("frame %0d mode %0d done", k, c[1:0]);
			prev = c;
		end
		repeat (20) @(negedge sys_clk_in);
		report_and_stop();
	end

	initial begin
		repeat (40000) @(posedge sys_clk_in);
		n_errors++;
		report_and_stop();
	end
endmodule
